// ### hdl/rxim_defs.vh
// Purpose: shared constants of the receive interrupt-enable and loop-code
//          register group
// Assumes: included by bare name from every rxim design file
// Notes: register offsets are word indices; byte address is index times 4
`ifndef RXIM_DEFS_VH
`define RXIM_DEFS_VH

// ****************************************
// register indices
// ****************************************
`define RXIM_IDX_FIFO_EN 8'hA4
`define RXIM_IDX_CODE_EN 8'hA6
`define RXIM_IDX_SIG_EN0 8'hA8
`define RXIM_IDX_SIG_EN1 8'hA9
`define RXIM_IDX_SIG_EN2 8'hAA
`define RXIM_IDX_SIG_EN3 8'hAB
`define RXIM_IDX_UP_HI 8'hAC
`define RXIM_IDX_UP_LO 8'hAD
`define RXIM_IDX_DN_HI 8'hAE
`define RXIM_IDX_DN_LO 8'hAF
`define RXIM_IDX_IRQ_STAT 8'hF0
`define RXIM_IDX_IRQ_CLR 8'hF1
`define RXIM_IDX_IRQ_EN 8'hF2

// ****************************************
// field layouts and reset values
// ****************************************
`define RXIM_RST_BYTE 8'h00
`define RXIM_FIFO_MASK 8'h03
`define RXIM_T1_CODE_MASK 8'h3F
`define RXIM_E1_CODE_MASK 8'h03
`define RXIM_FIFO_HWM_BIT 1
`define RXIM_FIFO_NE_BIT 0
`define RXIM_T1_RAI_BIT 5
`define RXIM_T1_AIS_BIT 4
`define RXIM_T1_SLC_BIT 3
`define RXIM_T1_FDL_BIT 2
`define RXIM_T1_BOCC_BIT 1
`define RXIM_T1_BOCD_BIT 0
`define RXIM_E1_SA6_BIT 1
`define RXIM_E1_SAX_BIT 0
`define RXIM_IRQ_W 3
`define RXIM_IRQ_SIG_BIT 0
`define RXIM_IRQ_LUP_BIT 1
`define RXIM_IRQ_LDN_BIT 2
`define RXIM_E1_CH_LO 24

// ****************************************
// bus answers and timing
// ****************************************
`define RXIM_RESP_OKAY 2'b00
`define RXIM_RESP_SLVERR 2'b10
`define RXIM_INTEG_BITS 64
`define RXIM_INTEG_W 8

`endif

// ### hdl/rxim_loop_det.v
// Purpose: repeating loop-code detector with length select and restart
// Assumes: received bits arrive on aclk with a one-cycle valid strobe
// Notes: pattern is {pat_hi, pat_lo} taken from bit 15 down
`timescale 1ns/10ps
`include "rxim_defs.vh"

module rxim_loop_det #(
  parameter CNT_W = `RXIM_INTEG_W,
  parameter [CNT_W-1:0] INTEG_BITS = `RXIM_INTEG_BITS
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire enable,
  input wire restart,
  input wire [3:0] code_len,
  input wire [7:0] pat_hi,
  input wire [7:0] pat_lo,
  // received stream
  input wire rx_bit,
  input wire rx_bit_valid,
  // result
  output reg detected_reg
);

  reg [3:0] phase_reg;
  reg [CNT_W-1:0] count_reg;
  wire [15:0] pat = {pat_hi, pat_lo};
  // code_len of 0 wraps to a 16-bit code
  wire [3:0] len_m1 = code_len - 4'h1;
  // phase 0 points at bit 7 of the first register [R12]
  // short lengths never reach the low bits or the second register [R13] [R14]
  wire expected = pat[~phase_reg];
  wire at_end = (phase_reg == len_m1);

  // compare bit by bit; a mismatch restarts the count so that only a
  // steady repeat integrates up to detection [R15] [R16]
  always @(posedge aclk)
  begin
    if (!aresetn || restart || !enable) // [R11]
    begin
      phase_reg <= 4'h0;
      count_reg <= {CNT_W{1'b0}};
      detected_reg <= 1'b0;
    end
    else if (rx_bit_valid)
    begin
      if (rx_bit == expected)
      begin
        phase_reg <= at_end ? 4'h0 : phase_reg + 4'h1;
        if (count_reg != INTEG_BITS)
          count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        detected_reg <= (count_reg + {{(CNT_W-1){1'b0}}, 1'b1})
                        >= INTEG_BITS;
      end
      else if (rx_bit == pat[15])
      begin
        // resync: this bit may be the start of the pattern
        phase_reg <= (len_m1 == 4'h0) ? 4'h0 : 4'h1;
        count_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
        detected_reg <= 1'b0;
      end
      else
      begin
        phase_reg <= 4'h0;
        count_reg <= {CNT_W{1'b0}};
        detected_reg <= 1'b0;
      end
    end
  end

endmodule

// ### hdl/rxim_sig_cos.v
// Purpose: per-channel signaling change-of-state detector
// Assumes: signaling words are updated on aclk with sig_valid
// Notes: first sample after reset only primes the history
`timescale 1ns/10ps
`include "rxim_defs.vh"

module rxim_sig_cos #(
  parameter CH = 32,
  parameter SIG_W = 4
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // signaling input
  input wire sig_valid,
  input wire [CH*SIG_W-1:0] sig_data,
  input wire [CH-1:0] ch_enable,
  // one-cycle change pulse
  output reg change_reg
);

  reg [CH*SIG_W-1:0] prev_reg;
  reg primed_reg;
  wire [CH-1:0] diff;

  // only enabled channels can report a change [R09]
  genvar i;
  generate
    for (i = 0; i < CH; i = i + 1)
    begin : g_ch
      assign diff[i] = ch_enable[i] &
        (sig_data[i*SIG_W +: SIG_W] != prev_reg[i*SIG_W +: SIG_W]);
    end
  endgenerate

  // history and pulse
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_reg <= {(CH*SIG_W){1'b0}};
      primed_reg <= 1'b0;
      change_reg <= 1'b0;
    end
    else
    begin
      change_reg <= sig_valid & primed_reg & (|diff); // [R09]
      if (sig_valid)
      begin
        prev_reg <= sig_data;
        primed_reg <= 1'b1;
      end
    end
  end

endmodule

// ### hdl/rxim_regs.v
// Purpose: receive interrupt-enable and loop-code register group, one port
// Assumes: AXI4-Lite slave, one write and one read at a time, aclk only
// Notes: registers are 8-bit in the low byte of each aligned word
//
// Notes on behaviour
// R01 - packet FIFO enable bit 1 gates the above-high-watermark event
// R02 - packet FIFO enable bit 0 gates the FIFO not-empty event
// R03 - T1 code/link enable: bit 5 remote alarm CI, bit 4 AIS CI
// R04 - T1 code/link enable: bit 3 SLC-96, bit 2 data-link full
// R05 - T1 code/link enable: bit 1 code clear, bit 0 code detect
// R06 - E1 layout at same offset: bit 1 enables Sa6 codeword event
// R07 - E1 layout bit 0 enables spare-bit change event
// R08 - four per-channel signaling change enables, fourth only in E1
// R09 - enabled channel signaling change sets the signaling change flag
// R10 - loop-up and loop-down definition registers, 8-bit, reset zero, T1
// R11 - writing first up or down definition register restarts integration
// R12 - pattern starts at bit 7 of first definition register
// R13 - length L below 8 compares only top L bits of first register
// R14 - second definition registers ignored for lengths 1 to 7
// R15 - loop-up detected while stream carries the loop-up pattern
// R16 - loop-down detected while stream carries the loop-down pattern
// R17 - interrupt contribution is flag AND its enable bit
// R18 - loop-code length comes in from a separate control input
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "rxim_defs.vh"

module rxim_regs #(
  parameter ADDR_W = 10,
  parameter CH = 32,
  parameter SIG_W = 4,
  parameter INTEG_BITS = `RXIM_INTEG_BITS
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // mode and loop-code length
  input wire e1_mode,
  input wire [3:0] loop_len,
  // received bit stream and signaling
  input wire rx_bit,
  input wire rx_bit_valid,
  input wire sig_valid,
  input wire [CH*SIG_W-1:0] sig_data,
  // latched status flags from the status block
  input wire [1:0] fifo_flags,
  input wire [5:0] code_link_flags,
  // decoded enables
  output reg fifo_high_mark_int_en,
  output reg fifo_nonempty_int_en,
  output reg remote_alarm_ci_int_en,
  output reg alarm_ind_ci_int_en,
  output reg slc_frame_int_en,
  output reg datalink_full_int_en,
  output reg bit_code_clear_int_en,
  output reg bit_code_detect_int_en,
  output reg spare6_codeword_int_en,
  output reg spare_bits_change_int_en,
  // gated contributions
  output reg [1:0] fifo_int_pending,
  output reg [5:0] code_link_int_pending,
  // detector and flag outputs
  output wire loop_up_detected,
  output wire loop_down_detected,
  output reg signaling_change_flag,
  output reg irq
);

  // ****************************************
  // decode helpers
  // ****************************************
  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `RXIM_IDX_FIFO_EN, `RXIM_IDX_CODE_EN,
        `RXIM_IDX_SIG_EN0, `RXIM_IDX_SIG_EN1,
        `RXIM_IDX_SIG_EN2, `RXIM_IDX_SIG_EN3,
        `RXIM_IDX_UP_HI, `RXIM_IDX_UP_LO,
        `RXIM_IDX_DN_HI, `RXIM_IDX_DN_LO,
        `RXIM_IDX_IRQ_STAT, `RXIM_IDX_IRQ_CLR,
        `RXIM_IDX_IRQ_EN: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] fifo_en_reg;
  reg [7:0] code_en_reg;
  reg [CH-1:0] sig_en_reg;
  reg [7:0] up_hi_reg;
  reg [7:0] up_lo_reg;
  reg [7:0] dn_hi_reg;
  reg [7:0] dn_lo_reg;
  reg [`RXIM_IRQ_W-1:0] irq_stat_reg;
  reg [`RXIM_IRQ_W-1:0] irq_en_reg;
  reg [`RXIM_IRQ_W-1:0] irq_stat_next;
  reg lup_prev_reg;
  reg ldn_prev_reg;

  // write channel holding state
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_idx_reg;
  reg [7:0] wdata_reg;
  reg wstrb_reg;

  wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire wr_ok = wr_fire & mapped(aw_idx_reg);
  wire wr_byte = wr_ok & wstrb_reg;
  wire [7:0] code_mask = e1_mode ? `RXIM_E1_CODE_MASK : `RXIM_T1_CODE_MASK;
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  wire sig_change;

  // ****************************************
  // axi4-lite write path
  // ****************************************
  // address and data are caught in either order; ready stays low from
  // capture until the response is taken, which limits us to one write
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RXIM_RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx_reg <= s_axi_awaddr[9:2];
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_idx_reg) ? `RXIM_RESP_OKAY
                                          : `RXIM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // loop-code registers are kept even in E1 so a mode flip loses nothing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_en_reg <= `RXIM_RST_BYTE;
      code_en_reg <= `RXIM_RST_BYTE;
      sig_en_reg <= {CH{1'b0}};
      up_hi_reg <= `RXIM_RST_BYTE; // [R10]
      up_lo_reg <= `RXIM_RST_BYTE;
      dn_hi_reg <= `RXIM_RST_BYTE;
      dn_lo_reg <= `RXIM_RST_BYTE;
      irq_en_reg <= {`RXIM_IRQ_W{1'b0}};
    end
    else if (wr_byte)
    begin
      case (aw_idx_reg)
        `RXIM_IDX_FIFO_EN: fifo_en_reg <= wdata_reg & `RXIM_FIFO_MASK;
        // the T1 and E1 layouts share one offset [R03] [R06]
        `RXIM_IDX_CODE_EN: code_en_reg <= wdata_reg & code_mask;
        `RXIM_IDX_SIG_EN0: sig_en_reg[7:0] <= wdata_reg; // [R08]
        `RXIM_IDX_SIG_EN1: sig_en_reg[15:8] <= wdata_reg;
        `RXIM_IDX_SIG_EN2: sig_en_reg[23:16] <= wdata_reg;
        `RXIM_IDX_SIG_EN3: sig_en_reg[31:24] <= wdata_reg;
        `RXIM_IDX_UP_HI: up_hi_reg <= wdata_reg;
        `RXIM_IDX_UP_LO: up_lo_reg <= wdata_reg;
        `RXIM_IDX_DN_HI: dn_hi_reg <= wdata_reg;
        `RXIM_IDX_DN_LO: dn_lo_reg <= wdata_reg;
        `RXIM_IDX_IRQ_EN: irq_en_reg <= wdata_reg[`RXIM_IRQ_W-1:0];
        default: fifo_en_reg <= fifo_en_reg;
      endcase
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  // the clear register is write-only and reads zero; reads have no side
  // effect, so a repeated read is always safe
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RXIM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(ar_idx) ? `RXIM_RESP_OKAY : `RXIM_RESP_SLVERR;
      case (ar_idx)
        `RXIM_IDX_FIFO_EN: s_axi_rdata <= {24'h000000, fifo_en_reg};
        `RXIM_IDX_CODE_EN:
          s_axi_rdata <= {24'h000000, code_en_reg & code_mask};
        `RXIM_IDX_SIG_EN0: s_axi_rdata <= {24'h000000, sig_en_reg[7:0]};
        `RXIM_IDX_SIG_EN1: s_axi_rdata <= {24'h000000, sig_en_reg[15:8]};
        `RXIM_IDX_SIG_EN2: s_axi_rdata <= {24'h000000, sig_en_reg[23:16]};
        `RXIM_IDX_SIG_EN3: s_axi_rdata <= {24'h000000, sig_en_reg[31:24]};
        `RXIM_IDX_UP_HI: s_axi_rdata <= {24'h000000, up_hi_reg};
        `RXIM_IDX_UP_LO: s_axi_rdata <= {24'h000000, up_lo_reg};
        `RXIM_IDX_DN_HI: s_axi_rdata <= {24'h000000, dn_hi_reg};
        `RXIM_IDX_DN_LO: s_axi_rdata <= {24'h000000, dn_lo_reg};
        `RXIM_IDX_IRQ_STAT:
          s_axi_rdata <= {29'h00000000, irq_stat_reg};
        `RXIM_IDX_IRQ_EN:
          s_axi_rdata <= {29'h00000000, irq_en_reg};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // detectors
  // ****************************************
  // loop detectors only run in T1; the length comes from outside [R18]
  rxim_loop_det #(
    .CNT_W(`RXIM_INTEG_W),
    .INTEG_BITS(INTEG_BITS[`RXIM_INTEG_W-1:0])
  ) u_up_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(~e1_mode),
    .restart(wr_byte && (aw_idx_reg == `RXIM_IDX_UP_HI)), // [R11]
    .code_len(loop_len),
    .pat_hi(up_hi_reg),
    .pat_lo(up_lo_reg),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid),
    .detected_reg(loop_up_detected) // [R15]
  );

  rxim_loop_det #(
    .CNT_W(`RXIM_INTEG_W),
    .INTEG_BITS(INTEG_BITS[`RXIM_INTEG_W-1:0])
  ) u_dn_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(~e1_mode),
    .restart(wr_byte && (aw_idx_reg == `RXIM_IDX_DN_HI)), // [R11]
    .code_len(loop_len),
    .pat_hi(dn_hi_reg),
    .pat_lo(dn_lo_reg),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid),
    .detected_reg(loop_down_detected) // [R16]
  );

  // channels 25 to 32 only count in E1 [R08]
  rxim_sig_cos #(
    .CH(CH),
    .SIG_W(SIG_W)
  ) u_sig_cos (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_valid(sig_valid),
    .sig_data(sig_data),
    .ch_enable({sig_en_reg[CH-1:`RXIM_E1_CH_LO] &
                {(CH-`RXIM_E1_CH_LO){e1_mode}},
                sig_en_reg[`RXIM_E1_CH_LO-1:0]}),
    .change_reg(sig_change)
  );

  // ****************************************
  // sticky status and interrupt
  // ****************************************
  // a new event in the clearing cycle survives: set wins over clear
  always @*
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_byte && (aw_idx_reg == `RXIM_IDX_IRQ_CLR))
      irq_stat_next = irq_stat_next & ~wdata_reg[`RXIM_IRQ_W-1:0];
    if (sig_change)
      irq_stat_next[`RXIM_IRQ_SIG_BIT] = 1'b1; // [R09]
    if (loop_up_detected && !lup_prev_reg)
      irq_stat_next[`RXIM_IRQ_LUP_BIT] = 1'b1;
    if (loop_down_detected && !ldn_prev_reg)
      irq_stat_next[`RXIM_IRQ_LDN_BIT] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= {`RXIM_IRQ_W{1'b0}};
      lup_prev_reg <= 1'b0;
      ldn_prev_reg <= 1'b0;
      signaling_change_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      lup_prev_reg <= loop_up_detected;
      ldn_prev_reg <= loop_down_detected;
      signaling_change_flag <= irq_stat_next[`RXIM_IRQ_SIG_BIT]; // [R09]
      irq <= |(irq_stat_next & irq_en_reg);
    end
  end

  // ****************************************
  // decoded enables and gated contributions
  // ****************************************
  // registered so every output leaves on a flop; costs one cycle of lag
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_high_mark_int_en <= 1'b0;
      fifo_nonempty_int_en <= 1'b0;
      remote_alarm_ci_int_en <= 1'b0;
      alarm_ind_ci_int_en <= 1'b0;
      slc_frame_int_en <= 1'b0;
      datalink_full_int_en <= 1'b0;
      bit_code_clear_int_en <= 1'b0;
      bit_code_detect_int_en <= 1'b0;
      spare6_codeword_int_en <= 1'b0;
      spare_bits_change_int_en <= 1'b0;
      fifo_int_pending <= 2'b00;
      code_link_int_pending <= 6'h00;
    end
    else
    begin
      fifo_high_mark_int_en <= fifo_en_reg[`RXIM_FIFO_HWM_BIT]; // [R01]
      fifo_nonempty_int_en <= fifo_en_reg[`RXIM_FIFO_NE_BIT]; // [R02]
      remote_alarm_ci_int_en <= ~e1_mode &
                                code_en_reg[`RXIM_T1_RAI_BIT]; // [R03]
      alarm_ind_ci_int_en <= ~e1_mode & code_en_reg[`RXIM_T1_AIS_BIT];
      slc_frame_int_en <= ~e1_mode & code_en_reg[`RXIM_T1_SLC_BIT]; // [R04]
      datalink_full_int_en <= ~e1_mode & code_en_reg[`RXIM_T1_FDL_BIT];
      bit_code_clear_int_en <= ~e1_mode &
                               code_en_reg[`RXIM_T1_BOCC_BIT]; // [R05]
      bit_code_detect_int_en <= ~e1_mode & code_en_reg[`RXIM_T1_BOCD_BIT];
      spare6_codeword_int_en <= e1_mode &
                                code_en_reg[`RXIM_E1_SA6_BIT]; // [R06]
      spare_bits_change_int_en <= e1_mode &
                                  code_en_reg[`RXIM_E1_SAX_BIT]; // [R07]
      fifo_int_pending <= fifo_flags & fifo_en_reg[1:0]; // [R17]
      code_link_int_pending <= code_link_flags &
                               code_en_reg[5:0] & code_mask[5:0]; // [R17]
    end
  end

endmodule

// ### tb/rxim_regs_asserts.sv
// Purpose: port-level checks of the receive enable register group
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound onto rxim_regs from tb_top
`timescale 1ns/10ps

module rxim_regs_asserts (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // mode, flags and results
  input logic e1_mode,
  input logic rx_bit_valid,
  input logic [1:0] fifo_flags,
  input logic [1:0] fifo_int_pending,
  input logic fifo_high_mark_int_en,
  input logic fifo_nonempty_int_en,
  input logic spare6_codeword_int_en,
  input logic remote_alarm_ci_int_en,
  input logic loop_up_detected,
  input logic loop_down_detected
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  hwm_gate_a: assert property (
    fifo_int_pending[1] == ($past(fifo_flags[1]) && fifo_high_mark_int_en))
    else $error("hwm pend");
  ne_gate_a: assert property (
    fifo_int_pending[0] == ($past(fifo_flags[0]) && fifo_nonempty_int_en))
    else $error("ne pend");
  t1_layout_a: assert property (
    remote_alarm_ci_int_en |-> !$past(e1_mode)) else $error("t1 bit in e1");
  e1_layout_a: assert property (
    spare6_codeword_int_en |-> $past(e1_mode)) else $error("e1 bit in t1");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  byte_wide_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata wide");
  loop_t1_a: assert property (
    e1_mode [*2] |-> !loop_up_detected && !loop_down_detected)
    else $error("loop detect in e1");
  up_rise_a: assert property (
    $rose(loop_up_detected) |-> $past(rx_bit_valid)) else $error("up rise");

  cover property (loop_up_detected);
  cover property (loop_down_detected);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench of the receive enable register group
// Assumes: AXI4-Lite master tasks, short integration count of 8 bits
// Notes: expected values come from the register map, not from the dut
`timescale 1ns/10ps

module tb_top;
  // dut ports
  logic aclk = 0, aresetn = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic e1_mode = 0, rx_bit = 0, rx_bit_valid = 0, sig_valid = 0;
  logic [3:0] loop_len = 4'h3;
  logic [127:0] sig_data = 0;
  logic [1:0] fifo_flags = 0, fifo_int_pending;
  logic [5:0] code_link_flags = 0, code_link_int_pending;
  logic fifo_high_mark_int_en, fifo_nonempty_int_en;
  logic remote_alarm_ci_int_en, alarm_ind_ci_int_en, slc_frame_int_en;
  logic datalink_full_int_en, bit_code_clear_int_en, bit_code_detect_int_en;
  logic spare6_codeword_int_en, spare_bits_change_int_en;
  logic loop_up_detected, loop_down_detected, signaling_change_flag, irq;
  int n_fail = 0, checks = 0;
  wire [5:0] t1_en = {remote_alarm_ci_int_en, alarm_ind_ci_int_en,
    slc_frame_int_en, datalink_full_int_en, bit_code_clear_int_en,
    bit_code_detect_int_en};
  wire [1:0] e1_en = {spare6_codeword_int_en, spare_bits_change_int_en};

  rxim_regs #(.INTEG_BITS(8)) i_dut (.*);

  // 250 MHz clock
  initial forever #2 aclk = ~aclk;

  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // enables and pending lag the register by a cycle each
  task settle;
    repeat (3) @(posedge aclk);
  endtask

  task axi_wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write answer");
  endtask

  task axi_rd(input logic [7:0] idx, input logic [7:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er}, "read answer");
    chk(s_axi_rdata, {24'h0, ed}, "read data");
  endtask

  // repeating 3-bit code, first bit from the top
  task send(input logic [2:0] p, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_bit <= p[2 - i % 3];
      rx_bit_valid <= 1;
      @(posedge aclk);
    end
    rx_bit_valid <= 0;
  endtask

  task sig(input logic [127:0] d);
    sig_data <= d;
    sig_valid <= 1;
    @(posedge aclk);
    sig_valid <= 0;
    repeat (5) @(posedge aclk);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog at 10k cycles, well past the expected three hundred or so
  initial
  begin
    #40000;
    n_fail++;
    report_and_stop;
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 'hA4; i <= 'hAF; i++)
      axi_rd(i[7:0], 8'h00,
        (i == 'hA5 || i == 'hA7) ? 2'b10 : 2'b00);
    axi_wr(8'h30, 8'h55, 2'b10);
    fifo_flags <= 2'b11;
    axi_wr(8'hA4, 8'h02, 2'b00);
    settle;
    chk({fifo_high_mark_int_en, fifo_nonempty_int_en, fifo_int_pending},
      4'hA, "fifo high mark");
    axi_wr(8'hA4, 8'h01, 2'b00);
    settle;
    chk({fifo_high_mark_int_en, fifo_nonempty_int_en, fifo_int_pending},
      4'h5, "fifo not empty");
    code_link_flags <= 6'h3F;
    for (int b = 0; b < 6; b++)
    begin
      axi_wr(8'hA6, 8'h01 << b, 2'b00);
      settle;
      chk({t1_en, code_link_int_pending}, {6'h01 << b, 6'h01 << b},
        "t1");
    end
    axi_wr(8'hA6, 8'hFF, 2'b00);
    axi_rd(8'hA6, 8'h3F, 2'b00);
    e1_mode <= 1;
    axi_wr(8'hA6, 8'hFF, 2'b00);
    settle;
    chk({t1_en, e1_en, code_link_int_pending}, 14'h00C3, "e1");
    axi_rd(8'hA6, 8'h03, 2'b00);
    axi_wr(8'hA6, 8'h01, 2'b00);
    settle;
    chk(e1_en, 2'b01, "e1 spare change");
    // channel 1 and channel 25 enabled, irq on signaling change
    axi_wr(8'hF2, 8'h01, 2'b00);
    axi_wr(8'hA8, 8'h01, 2'b00);
    axi_wr(8'hAB, 8'h01, 2'b00);
    e1_mode <= 0;
    sig(128'h0);
    sig(128'h10);
    chk({irq, signaling_change_flag}, 2'b00, "ch2 masked");
    sig({4'h1, 96'h10});
    chk({irq, signaling_change_flag}, 2'b00, "ch25 in t1");
    sig({4'h1, 96'h11});
    chk({irq, signaling_change_flag}, 2'b11, "ch1 change");
    axi_rd(8'hF0, 8'h01, 2'b00);
    axi_wr(8'hF1, 8'h01, 2'b00);
    settle;
    chk({irq, signaling_change_flag}, 2'b00, "cleared");
    e1_mode <= 1;
    axi_wr(8'hF2, 8'h00, 2'b00);
    sig({4'h2, 96'h11});
    chk({irq, signaling_change_flag}, 2'b01, "ch25 in e1, masked");
    axi_wr(8'hF1, 8'h01, 2'b00);
    // loop codes: length 3, low bits of both registers are noise
    e1_mode <= 0;
    axi_wr(8'hAC, 8'hB7, 2'b00);
    axi_wr(8'hAD, 8'h5A, 2'b00);
    // down code 100 is no rotation of the up code 101
    axi_wr(8'hAE, 8'h9F, 2'b00);
    axi_wr(8'hAF, 8'hFF, 2'b00);
    send(3'b101, 12);
    settle;
    chk({loop_up_detected, loop_down_detected}, 2'b10,
      "up");
    send(3'b000, 1);
    settle;
    chk(loop_up_detected, 1'b0, "up drop");
    send(3'b101, 6);
    axi_wr(8'hAC, 8'hB7, 2'b00);
    send(3'b101, 3);
    settle;
    chk(loop_up_detected, 1'b0, "restart");
    send(3'b101, 6);
    settle;
    chk(loop_up_detected, 1'b1, "after restart");
    send(3'b100, 12);
    settle;
    chk({loop_up_detected, loop_down_detected}, 2'b01, "down");
    // up detector has risen twice and down detector once, signaling bit was cleared
    axi_rd(8'hF0, 8'h06, 2'b00);
    e1_mode <= 1;
    settle;
    chk({loop_up_detected, loop_down_detected}, 2'b00, "e1 off");
    report_and_stop;
  end
endmodule

bind rxim_regs rxim_regs_asserts i_chk (.*);
